// File: irq_ctrl_regs.vh
// Vector addresses, level codes and sizes of the multilevel interrupt controller.
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// ****************************************************************
// Sizes
// ****************************************************************
`define IRQ_NUM_SRC 32
`define IRQ_SRC_IDX_W 5
`define IRQ_VEC_W 16

// ****************************************************************
// Level encodings
// ****************************************************************
`define IRQ_LVL_OFF 2'h0
`define IRQ_LVL_LOW 2'h1
`define IRQ_LVL_MED 2'h2
`define IRQ_LVL_HIGH 2'h3

// ****************************************************************
// Reset and idle values
// ****************************************************************
`define IRQ_RR_LAST_RESET 5'h1F
`define IRQ_NO_VECTOR 16'hFFFF

// ****************************************************************
// Vector word addresses
// ****************************************************************
`define RESET_VECTOR 16'h0000
`define OSC_FAIL_VECTOR 16'h0002
`define PORT_R_PIN_VECTOR 16'h0004
`define DMA_VECTOR_BASE 16'h0006
`define RTC_VECTOR_BASE 16'h000E
`define PORT_C_PIN_VECTOR 16'h0012
`define TWOWIRE_C_VECTOR_BASE 16'h0014
`define TIMER_C_QUAD_VECTOR_BASE 16'h0018
`define TIMER_C_DUAL_VECTOR_BASE 16'h0024
`define SPI_C_VECTOR 16'h002C
`define SERIAL_C_VECTOR_BASE 16'h002E
`define NONVOL_VECTOR_BASE 16'h0034
`define PROGLOGIC_VECTOR_BASE 16'h0038
`define PORT_A_PIN_VECTOR 16'h003C
`define COMPARATOR_A_VECTOR_BASE 16'h003E
`define CONVERTER_A_VECTOR_BASE 16'h0044
`define PORT_D_PIN_VECTOR 16'h0046
`define TIMER_D_DUAL_VECTOR_BASE 16'h0048
`define SERIAL_D_VECTOR_BASE 16'h0050

`endif

// File: multilevel_irq_ctrl.v
// Multilevel interrupt controller with level preemption and vector output.
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"

// Overview of operation
// - Sources request only when enabled and pending.
// - Each source picks low, medium or high.
// - Medium preempts running low handler.
// - High preempts medium and low handlers.
// - Same level: lowest vector address wins.
// - Optional round-robin rotation for low level.
// - Oscillator failure interrupt ignores level enables.
// - Acknowledge loads program counter with vector.
// - Vector is peripheral base plus offset when src_in_peripheral is set, else the base alone.
// - Vectors are program word addresses.
// - Table relocatable to boot loader section.
// - Reset at 0x0000, oscillator failure 0x0002.
// - Pin-change vectors for ports R, C, A.
// - DMA, RTC, two-wire base addresses.
// - Timer base addresses for ports C, D.
// - SPI vector for port C, serial vectors for ports C, D.
// - Nonvolatile, logic, comparator base addresses.
// - Converter base and port D pin vector.

module multilevel_irq_ctrl (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Peripheral sources: asynchronous conditions and configuration
	input wire [31:0] src_cond,
	input wire [31:0] src_enable,
	input wire [63:0] src_level,
	input wire [159:0] src_offset,
	input wire [31:0] src_in_peripheral,
	// Non-maskable oscillator failure condition, asynchronous
	input wire osc_fail,
	// Controller configuration
	input wire low_enable,
	input wire med_enable,
	input wire high_enable,
	input wire round_robin,
	input wire boot_vectors,
	input wire [15:0] boot_base,
	// Core handshake
	input wire core_ready,
	input wire handler_return,
	// Core side outputs
	output reg irq_req,
	output reg pc_load,
	output reg [15:0] pc_vector,
	output reg [4:0] ack_src,
	output reg ack_nmi,
	// Status
	output reg nmi_active,
	output reg high_active,
	output reg med_active,
	output reg low_active,
	output reg [4:0] rr_last
);

// ****************************************************************
// Synchronisers
// ****************************************************************
reg [31:0] cond_s1;
reg [31:0] cond_s2;
reg osc_s1;
reg osc_s2;

always @(posedge mclk) begin
	if (rst) begin
		cond_s1 <= 32'h00000000;
		cond_s2 <= 32'h00000000;
	end else begin
		cond_s1 <= src_cond;
		cond_s2 <= cond_s1;
	end
end

// The oscillator failure line has its own pair of flops.
always @(posedge mclk) begin
	if (rst) begin
		osc_s1 <= 1'b0;
		osc_s2 <= 1'b0;
	end else begin
		osc_s1 <= osc_fail;
		osc_s2 <= osc_s1;
	end
end

// ****************************************************************
// Vector base table
// ****************************************************************
// Source indexes 0x00 to 0x10 map to a peripheral base, the others to IRQ_NO_VECTOR; a source with its src_in_peripheral
// bit set adds its own offset, any other source uses the base alone.
function [15:0] base_of;
	input [4:0] idx;
	begin
		case (idx)
			5'h00: base_of = `PORT_R_PIN_VECTOR;
			5'h01: base_of = `DMA_VECTOR_BASE;
			5'h02: base_of = `RTC_VECTOR_BASE;
			5'h03: base_of = `PORT_C_PIN_VECTOR;
			5'h04: base_of = `TWOWIRE_C_VECTOR_BASE;
			5'h05: base_of = `TIMER_C_QUAD_VECTOR_BASE;
			5'h06: base_of = `TIMER_C_DUAL_VECTOR_BASE;
			5'h07: base_of = `SPI_C_VECTOR;
			5'h08: base_of = `SERIAL_C_VECTOR_BASE;
			5'h09: base_of = `NONVOL_VECTOR_BASE;
			5'h0A: base_of = `PROGLOGIC_VECTOR_BASE;
			5'h0B: base_of = `PORT_A_PIN_VECTOR;
			5'h0C: base_of = `COMPARATOR_A_VECTOR_BASE;
			5'h0D: base_of = `CONVERTER_A_VECTOR_BASE;
			5'h0E: base_of = `PORT_D_PIN_VECTOR;
			5'h0F: base_of = `TIMER_D_DUAL_VECTOR_BASE;
			5'h10: base_of = `SERIAL_D_VECTOR_BASE;
			default: base_of = `IRQ_NO_VECTOR;
		endcase
	end
endfunction

// ****************************************************************
// Request qualification and per-source vectors
// ****************************************************************
reg [31:0] req;
reg [15:0] vec [0:31];
reg [1:0] lvl [0:31];
integer i;

always @* begin
	for (i = 0; i < 32; i = i + 1) begin
		lvl[i] = src_level[2*i +: 2];
		req[i] = cond_s2[i] & src_enable[i] &
			(lvl[i] != `IRQ_LVL_OFF);
		// Word address: base plus offset, no byte scaling.
		vec[i] = base_of(i[4:0]) +
			(src_in_peripheral[i] ? {11'h000, src_offset[5*i +: 5]}
			: 16'h0000);
	end
end

// ****************************************************************
// Selection per level
// ****************************************************************
reg [31:0] req_hi;
reg [31:0] req_md;
reg [31:0] req_lo;
reg found_hi;
reg found_md;
reg found_lo;
reg [4:0] sel_hi;
reg [4:0] sel_md;
reg [4:0] sel_lo;
reg [15:0] best_hi;
reg [15:0] best_md;
reg [15:0] best_lo;
reg [4:0] rr_dist;
reg [4:0] best_dist;
integer j;
integer k;
integer m;
integer n;

// Split of the qualified requests by level.
always @* begin
	for (j = 0; j < 32; j = j + 1) begin
		req_hi[j] = req[j] & (lvl[j] == `IRQ_LVL_HIGH);
		req_md[j] = req[j] & (lvl[j] == `IRQ_LVL_MED);
		req_lo[j] = req[j] & (lvl[j] == `IRQ_LVL_LOW);
	end
end

// High level: the lowest vector address wins.
always @* begin
	found_hi = 1'b0;
	sel_hi = 5'h00;
	best_hi = `IRQ_NO_VECTOR;
	for (k = 0; k < 32; k = k + 1) begin
		if (req_hi[k] && (!found_hi || vec[k] < best_hi)) begin
			found_hi = 1'b1;
			best_hi = vec[k];
			sel_hi = k[4:0];
		end
	end
end

// Medium level: the lowest vector address wins.
always @* begin
	found_md = 1'b0;
	sel_md = 5'h00;
	best_md = `IRQ_NO_VECTOR;
	for (n = 0; n < 32; n = n + 1) begin
		if (req_md[n] && (!found_md || vec[n] < best_md)) begin
			found_md = 1'b1;
			best_md = vec[n];
			sel_md = n[4:0];
		end
	end
end

// Low level: fixed order, or a round robin that starts its search just
// after the source served last, so that no low source waits forever.
always @* begin
	found_lo = 1'b0;
	sel_lo = 5'h00;
	best_lo = `IRQ_NO_VECTOR;
	best_dist = 5'h1F;
	rr_dist = 5'h00;
	for (m = 0; m < 32; m = m + 1) begin
		rr_dist = m[4:0] - rr_last - 5'h01;
		if (req_lo[m] && (round_robin ? (!found_lo || rr_dist < best_dist)
			: (!found_lo || vec[m] < best_lo))) begin
			found_lo = 1'b1;
			best_lo = vec[m];
			best_dist = rr_dist;
			sel_lo = m[4:0];
		end
	end
end

// ****************************************************************
// Preemption decision
// ****************************************************************
reg take_nmi;
reg take_hi;
reg take_md;
reg take_lo;

always @* begin
	take_nmi = osc_s2 & ~nmi_active;
	take_hi = found_hi & high_enable & ~high_active & ~nmi_active;
	take_md = found_md & med_enable & ~high_active & ~med_active &
		~nmi_active;
	take_lo = found_lo & low_enable & ~high_active & ~med_active &
		~low_active & ~nmi_active;
end

// ****************************************************************
// Acknowledge and level bookkeeping
// ****************************************************************
reg any_take;
reg [15:0] next_vector;
reg next_irq_req;
reg next_pc_load;
reg [15:0] next_pc_vector;
reg [4:0] next_ack_src;
reg next_ack_nmi;
reg next_nmi_active;
reg next_high_active;
reg next_med_active;
reg next_low_active;
reg [4:0] next_rr_last;

always @* begin
	any_take = take_nmi | take_hi | take_md | take_lo;
	if (take_nmi)
		next_vector = `OSC_FAIL_VECTOR;
	else if (take_hi)
		next_vector = best_hi;
	else if (take_md)
		next_vector = best_md;
	else
		next_vector = best_lo;
	if (boot_vectors)
		next_vector = next_vector + boot_base;
end

// Next state of the core side outputs and of the levels in service. A
// return blocks any acknowledge in its cycle, so a level being released
// is never taken again at the same edge.
always @* begin
	next_irq_req = any_take;
	next_pc_load = 1'b0;
	next_pc_vector = pc_vector;
	next_ack_src = ack_src;
	next_ack_nmi = 1'b0;
	next_nmi_active = nmi_active;
	next_high_active = high_active;
	next_med_active = med_active;
	next_low_active = low_active;
	next_rr_last = rr_last;
	if (handler_return) begin
		// Release the highest level in service.
		if (nmi_active)
			next_nmi_active = 1'b0;
		else if (high_active)
			next_high_active = 1'b0;
		else if (med_active)
			next_med_active = 1'b0;
		else
			next_low_active = 1'b0;
	end else if (core_ready && any_take) begin
		next_pc_load = 1'b1;
		next_pc_vector = next_vector;
		if (take_nmi) begin
			next_nmi_active = 1'b1;
			next_ack_nmi = 1'b1;
		end else if (take_hi) begin
			next_high_active = 1'b1;
			next_ack_src = sel_hi;
		end else if (take_md) begin
			next_med_active = 1'b1;
			next_ack_src = sel_md;
		end else begin
			next_low_active = 1'b1;
			next_ack_src = sel_lo;
			next_rr_last = sel_lo;
		end
	end
end

// ****************************************************************
// Output registers
// ****************************************************************
always @(posedge mclk) begin
	if (rst) begin
		irq_req <= 1'b0;
		pc_load <= 1'b0;
		pc_vector <= `RESET_VECTOR;
		ack_src <= 5'h00;
		ack_nmi <= 1'b0;
		nmi_active <= 1'b0;
		high_active <= 1'b0;
		med_active <= 1'b0;
		low_active <= 1'b0;
		rr_last <= `IRQ_RR_LAST_RESET;
	end else begin
		irq_req <= next_irq_req;
		pc_load <= next_pc_load;
		pc_vector <= next_pc_vector;
		ack_src <= next_ack_src;
		ack_nmi <= next_ack_nmi;
		nmi_active <= next_nmi_active;
		high_active <= next_high_active;
		med_active <= next_med_active;
		low_active <= next_low_active;
		rr_last <= next_rr_last;
	end
end

endmodule // multilevel_irq_ctrl

// File: core_model.sv
// CPU core model that takes vectors and returns from handlers.
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Controller side
	input wire pc_load,
	input wire hold,
	input wire slow,
	output logic core_ready,
	output logic handler_return
);
	logic [2:0] cnt;
	always @(posedge mclk) begin
		if (rst) begin
			cnt <= 3'h0;
			core_ready <= 1'h0;
			handler_return <= 1'h0;
		end else begin
			core_ready <= slow ? ~core_ready : 1'h1;
			handler_return <= cnt == 3'h1 && !hold;
			if (pc_load)
				cnt <= 3'h4;
			else if (cnt > 3'h1 || (cnt == 3'h1 && !hold))
				cnt <= cnt - 3'h1;
		end
	end
endmodule // core_model

// File: multilevel_irq_ctrl_sva.sv
// Port assertions of the multilevel interrupt controller.
`timescale 1ns/1ps
module multilevel_irq_ctrl_sva (
	input wire mclk,
	input wire rst,
	input wire osc_fail,
	input wire boot_vectors,
	input wire [15:0] boot_base,
	input wire core_ready,
	input wire handler_return,
	input wire pc_load,
	input wire [15:0] pc_vector,
	input wire ack_nmi,
	input wire nmi_active,
	input wire high_active,
	input wire med_active,
	input wire low_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence fail_held;
		(osc_fail && !nmi_active && core_ready && !handler_return) [*3];
	endsequence
	fail_served_a:
		assert property (fail_held |=> ack_nmi || nmi_active) else $error("nmi lost");
	take_gate_a:
		assert property (pc_load |-> $past(core_ready) && !$past(handler_return))
		else $error("ack without ready");
	nmi_vector_a:
		assert property (ack_nmi |-> pc_load && pc_vector ==
			($past(boot_vectors) ? $past(boot_base) : 16'h0000) + 16'h0002)
		else $error("bad nmi vector");
	vector_hold_a:
		assert property (!pc_load |-> $stable(pc_vector)) else $error("vector moved");
	high_kept_a:
		assert property (pc_load && $past(high_active) |-> ack_nmi)
		else $error("high preempted");
	med_kept_a:
		assert property (pc_load && $past(med_active) |-> ack_nmi || high_active)
		else $error("medium preempted");
	low_kept_a:
		assert property (pc_load && $past(low_active) |->
			ack_nmi || high_active || $rose(med_active)) else $error("low preempted");
	low_release_a:
		assert property (handler_return && low_active && !med_active &&
			!high_active && !nmi_active |=> !low_active) else $error("low kept");
endmodule // multilevel_irq_ctrl_sva
bind multilevel_irq_ctrl multilevel_irq_ctrl_sva chk (.mclk(mclk), .rst(rst),
	.osc_fail(osc_fail), .boot_vectors(boot_vectors), .boot_base(boot_base),
	.core_ready(core_ready), .handler_return(handler_return),
	.pc_load(pc_load), .pc_vector(pc_vector), .ack_nmi(ack_nmi),
	.nmi_active(nmi_active), .high_active(high_active),
	.med_active(med_active), .low_active(low_active));

// File: tb_multilevel_irq_ctrl.sv
// Self-checking bench for the multilevel interrupt controller.
`timescale 1ns/1ps
module tb_multilevel_irq_ctrl;
	logic mclk = 0, rst = 1, osc_fail = 0, round_robin = 0, boot_vectors = 0;
	logic low_enable = 1, med_enable = 1, high_enable = 1, hold = 0, slow = 0;
	logic [31:0] src_cond = 0, src_enable = 0, src_in_peripheral = 0;
	logic [63:0] src_level = 0;
	logic [159:0] src_offset = 0;
	logic [15:0] boot_base = 0, v;
	logic [4:0] s;
	logic seen_req = 0;
	wire core_ready, handler_return, irq_req, pc_load, ack_nmi;
	wire nmi_active, high_active, med_active, low_active;
	wire [15:0] pc_vector;
	wire [4:0] ack_src, rr_last;
	integer n_fail = 0, n_compared = 0, seed = 32'h61CF, cyc = 0, i, a, b, lo;
	logic [15:0] bases [17] = '{16'h0004, 16'h0006, 16'h000E, 16'h0012,
		16'h0014, 16'h0018, 16'h0024, 16'h002C, 16'h002E, 16'h0034, 16'h0038,
		16'h003C, 16'h003E, 16'h0044, 16'h0046, 16'h0048, 16'h0050};
	multilevel_irq_ctrl dut (.mclk(mclk), .rst(rst), .src_cond(src_cond),
		.src_enable(src_enable), .src_level(src_level),
		.src_offset(src_offset), .src_in_peripheral(src_in_peripheral),
		.osc_fail(osc_fail), .low_enable(low_enable),
		.med_enable(med_enable), .high_enable(high_enable),
		.round_robin(round_robin), .boot_vectors(boot_vectors),
		.boot_base(boot_base), .core_ready(core_ready),
		.handler_return(handler_return), .irq_req(irq_req),
		.pc_load(pc_load), .pc_vector(pc_vector), .ack_src(ack_src),
		.ack_nmi(ack_nmi), .nmi_active(nmi_active),
		.high_active(high_active), .med_active(med_active),
		.low_active(low_active), .rr_last(rr_last));
	core_model cpu (.mclk(mclk), .rst(rst), .pc_load(pc_load), .hold(hold),
		.slow(slow), .core_ready(core_ready),
		.handler_return(handler_return));
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			wrap_up();
		end
	end
	task check(input [15:0] seen, input [15:0] want);
		n_compared = n_compared + 1;
		if (seen !== want) begin
			n_fail = n_fail + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task wrap_up;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function [15:0] vec(input integer k);
		vec = bases[k] + (src_in_peripheral[k] ? src_offset[k*5+:5] : 5'h00)
			+ (boot_vectors ? boot_base : 16'h0000);
	endfunction
	function integer lower(input integer x, input integer y);
		lower = (vec(y) < vec(x)) ? y : x;
	endfunction
	task take(output [4:0] src, output [15:0] pv);
		integer k;
		src = 5'h1F;
		pv = 16'hFFFF;
		for (k = 0; k < 30 && pc_load !== 1'b1; k++)
			@(negedge mclk);
		if (pc_load === 1'b1) begin
			src = ack_src;
			pv = pc_vector;
			seen_req = irq_req;
		end
		@(negedge mclk);
	endtask
	task restart;
		{rst, hold, src_cond} = {2'h2, 32'h0};
		repeat (3) @(negedge mclk);
		rst = 0;
		src_enable = $random(seed);
		src_in_peripheral = $random(seed);
		src_offset = {5{$random(seed)}};
	endtask
	task pair(input [1:0] la, input [1:0] lb);
		src_level[2*a+:2] = la;
		src_level[2*b+:2] = lb;
		{src_enable[a], src_enable[b], src_cond[a], src_cond[b]} = 4'hF;
	endtask
	initial begin
		repeat (2) @(negedge mclk);
		for (i = 0; i < 17; i++) begin
			restart();
			{boot_vectors, slow} = $random(seed);
			boot_base = $random(seed);
			src_level[2*i+:2] = 2'h1 + {$random(seed)} % 3;
			src_enable[i] = 1'h0;
			src_cond[i] = 1'h1;
			take(s, v);
			check(v, 16'hFFFF);
			check(irq_req, 1'b0);
			check(pc_vector, 16'h0000);
			src_enable[i] = 1'h1;
			take(s, v);
			check(v, vec(i));
			check(s, i);
			check(seen_req, 1'b1);
		end
		{slow, boot_vectors} = 2'h0;
		repeat (4) begin
			a = {$random(seed)} % 16;
			b = a + 1 + {$random(seed)} % (16 - a);
			for (i = 0; i < 2; i++) begin
				restart();
				round_robin = i;
				pair(2'h1, 2'h1);
				lo = lower(a, b);
				take(s, v);
				check(s, i ? a : lo);
				take(s, v);
				check(s, i ? b : lo);
				check(rr_last, i ? b : lo);
			end
			restart();
			hold = 1'h1;
			pair(2'h1, 2'h1);
			take(s, v);
			check(s, a);
			pair(2'h1, 2'h2);
			take(s, v);
			check(s, b);
			pair(2'h3, 2'h2);
			take(s, v);
			check(s, a);
			pair(2'h3, 2'h3);
			take(s, v);
			check(v, 16'hFFFF);
			check(irq_req, 1'b0);
			osc_fail = 1'h1;
			take(s, v);
			check(v, 16'h0002);
			osc_fail = 1'h0;
		end
		restart();
		{low_enable, med_enable, high_enable, boot_vectors} = 4'h1;
		pair(2'h3, 2'h1);
		take(s, v);
		check(v, 16'hFFFF);
		osc_fail = 1'h1;
		take(s, v);
		check(v, boot_base + 16'h0002);
		wrap_up();
	end
endmodule // tb_multilevel_irq_ctrl
